/* core/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;
    // register addresses on the special-function-register bus
    localparam logic [7:0] MASK_ADDR = 8'hA8;
    localparam logic [7:0] LEVEL_ADDR = 8'hB8;
    localparam logic [7:0] EXT_LEVEL_ADDR = 8'hF6;
    // values after reset
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] LEVEL_RESET = 8'h80;
    localparam logic [7:0] EXT_LEVEL_RESET = 8'h00;
    // field positions in the enable register
    localparam int GATE_BIT = 7;
    localparam int SERIAL_IFACE_BIT = 6;
    localparam int TIMER2_BIT = 5;
    localparam int SERIAL_PORT_BIT = 4;
    localparam int TIMER1_BIT = 3;
    localparam int EXT_LINE1_BIT = 2;
    localparam int TIMER0_BIT = 1;
    localparam int EXT_LINE0_BIT = 0;
    // reserved bit of the extended level register
    localparam int EXT_RSVD_BIT = 6;
    // source count and vector index width
    localparam int NUM_SOURCES = 14;
    localparam int VEC_W = 4;
    // cycle budget: one detect cycle plus four for the long call
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES = 4;
    localparam logic [2:0] CALL_COUNT = 3'(CALL_CYCLES - 1);
    // controller states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CALL = 2'b01
    } ctrl_state_t;
endpackage

/* core/two_level_interrupt_controller.sv */
// Function
// - fourteen sources, each pending flag and vector
// - software-set pending flag raises normal request
// - high level preempts a low routine
// - high routine is never preempted
// - all sources low level after reset
// - higher level first, ties by order
// - sample and decode every clock cycle
// - five cycles: detect plus four call
// - one instruction after return before call
// - worst case detect, return, divide, call
// - equal or lower level waits for return
// - global gate overrides all source masks
// - bits six and four mask serial units
// - bit five gates either timer 2 flag
// - bits three and one gate timers
// - bits two and zero gate external lines
// - level bits six to zero per source
// - level bit seven reads one, unwritable
// - extended level bits for extended sources
// - single-bit set/clear plus byte access
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_controller
    import irq_ctrl_pkg::*;
(
    input wire logic ref_clk, // system clock, 25 MHz
    input wire logic rst_b, // asynchronous reset, active low
    input wire logic [7:0] sfr_addr, // register address
    input wire logic [7:0] sfr_wdata, // byte write data
    input wire logic sfr_wr, // byte write strobe
    input wire logic sfr_bit_wr, // single-bit write strobe
    input wire logic [2:0] sfr_bit_sel, // bit number for single-bit write
    input wire logic sfr_bit_val, // value for single-bit write
    output logic [7:0] sfr_rdata, // read data for sfr_addr
    input wire logic ext_irq_line0, // external line 0 request, already detected
    input wire logic timer0_overflow_flag, // timer 0 pending flag
    input wire logic ext_irq_line1, // external line 1 request
    input wire logic timer1_overflow_flag, // timer 1 pending flag
    input wire logic serial_port_pend, // async serial port pending
    input wire logic timer2_low_overflow_flag, // timer 2 low byte flag
    input wire logic timer2_high_overflow_flag, // timer 2 high byte flag
    input wire logic serial_iface_pend, // serial peripheral unit pending
    input wire logic [6:0] ext_pend, // extended sources, already masked
    input wire logic instr_boundary, // core finishes an instruction this cycle
    input wire logic return_from_irq_instr, // core completes a return this cycle
    input wire logic call_ack, // core has taken the vector request
    output logic irq_req, // vector request to the core
    output logic [3:0] irq_vector, // index of source being vectored
    output logic in_service_hi, // high-level routine active
    output logic in_service_lo // low-level routine active
);
    // every piece of state in one record
    typedef struct packed {
        logic [7:0] mask_reg;
        logic [6:0] level_reg;
        logic [7:0] ext_level_reg;
        logic act_hi_reg;
        logic act_lo_reg;
        logic block_reg; // holds off one instruction after a return
        logic req_reg;
        logic [3:0] vec_reg;
        logic vec_hi_reg;
        logic [7:0] rdata_reg;
    } state_t;

    state_t cur_reg, cur_next;
    logic [13:0] pend; // raw pending vector in fixed order
    logic [13:0] lvl; // level per source
    logic [13:0] en; // enable per source
    logic [13:0] hi_cand, lo_cand;
    logic [3:0] hi_idx, lo_idx;
    logic [7:0] level_wr; // level register after any write, bit seven high unless written

    // lowest index set wins
    function automatic logic [3:0] first_set(input logic [13:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_SOURCES - 1; i >= 0; i--)
            if (v[i])
                r = 4'(i);
        return r;
    endfunction

    // merge a byte or single-bit write into a register
    function automatic logic [7:0] wr_merge(input logic [7:0] old, input logic byte_w,
        input logic bit_w, input logic [2:0] sel, input logic val, input logic [7:0] d);
        logic [7:0] r;
        r = old;
        if (byte_w)
            r = d;
        else if (bit_w)
            r[sel] = val;
        return r;
    endfunction

    // source order, matching vector order
    always_comb
    begin
        pend = {ext_pend, serial_iface_pend,
            timer2_low_overflow_flag | timer2_high_overflow_flag, serial_port_pend,
            timer1_overflow_flag, ext_irq_line1, timer0_overflow_flag, ext_irq_line0};
        lvl[6:0] = cur_reg.level_reg;
        lvl[13:7] = {cur_reg.ext_level_reg[7], cur_reg.ext_level_reg[5:0]};
        en[6:0] = cur_reg.mask_reg[6:0];
        // extended sources arrive already masked by their own unit
        en[13:7] = 7'h7F;
    end

    // decoding: gate, mask, level split
    always_comb
    begin
        // pending flag treated alike whoever set it
        hi_cand = cur_reg.mask_reg[GATE_BIT] ? (pend & en & lvl) : 14'h0000;
        lo_cand = cur_reg.mask_reg[GATE_BIT] ? (pend & en & ~lvl) : 14'h0000;
        hi_idx = first_set(hi_cand);
        lo_idx = first_set(lo_cand);
    end

    // next-state logic
    always_comb
    begin
        cur_next = cur_reg;
        // merged level byte; bit seven is not stored, so a write to it is lost
        level_wr = wr_merge({1'b1, cur_reg.level_reg}, sfr_wr, sfr_bit_wr,
            sfr_bit_sel, sfr_bit_val, sfr_wdata);
        // register writes
        // byte and single-bit access
        if (sfr_addr == MASK_ADDR)
            cur_next.mask_reg = wr_merge(cur_reg.mask_reg, sfr_wr, sfr_bit_wr,
                sfr_bit_sel, sfr_bit_val, sfr_wdata);
        if (sfr_addr == LEVEL_ADDR)
            cur_next.level_reg = level_wr[6:0];
        // reserved bit is stored as written; software keeps it zero
        if (sfr_addr == EXT_LEVEL_ADDR)
            cur_next.ext_level_reg = wr_merge(cur_reg.ext_level_reg, sfr_wr, sfr_bit_wr,
                sfr_bit_sel, sfr_bit_val, sfr_wdata);
        // one instruction completes after a return
        if (instr_boundary)
            cur_next.block_reg = 1'b0;
        if (return_from_irq_instr)
        begin
            if (cur_reg.act_hi_reg)
                cur_next.act_hi_reg = 1'b0;
            else
                cur_next.act_lo_reg = 1'b0;
            // next request waits one more instruction
            cur_next.block_reg = 1'b1;
        end
        // the core took the request: the routine's level becomes active
        if (cur_reg.req_reg && call_ack)
        begin
            cur_next.req_reg = 1'b0;
            if (cur_reg.vec_hi_reg)
                cur_next.act_hi_reg = 1'b1;
            else
                cur_next.act_lo_reg = 1'b1;
        end
        // decode every cycle; one detect cycle then the call
        else if (!cur_reg.req_reg && !cur_reg.block_reg && !return_from_irq_instr)
        begin
            // nothing enters above a high routine
            if (!cur_reg.act_hi_reg)
            begin
                if (hi_cand != 14'h0000)
                begin
                    cur_next.req_reg = 1'b1;
                    cur_next.vec_reg = hi_idx;
                    cur_next.vec_hi_reg = 1'b1;
                end
                // low waits while any routine runs
                else if (lo_cand != 14'h0000 && !cur_reg.act_lo_reg)
                begin
                    cur_next.req_reg = 1'b1;
                    cur_next.vec_reg = lo_idx;
                    cur_next.vec_hi_reg = 1'b0;
                end
            end
        end
        // read data; level bit seven reads one
        unique case (sfr_addr)
            MASK_ADDR: cur_next.rdata_reg = cur_next.mask_reg;
            LEVEL_ADDR: cur_next.rdata_reg = {1'b1, cur_next.level_reg};
            EXT_LEVEL_ADDR: cur_next.rdata_reg = cur_next.ext_level_reg;
            default: cur_next.rdata_reg = 8'h00;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur_reg <= '0;
            cur_reg.mask_reg <= MASK_RESET;
            cur_reg.level_reg <= LEVEL_RESET[6:0];
            cur_reg.ext_level_reg <= EXT_LEVEL_RESET;
            cur_reg.rdata_reg <= 8'h00;
        end
        else
            cur_reg <= cur_next;
    end

    // outputs straight from flip-flops
    // divide and return cycles are spent by the core via instr_boundary
    assign irq_req = cur_reg.req_reg;
    assign irq_vector = cur_reg.vec_reg;
    assign in_service_hi = cur_reg.act_hi_reg;
    assign in_service_lo = cur_reg.act_lo_reg;
    assign sfr_rdata = cur_reg.rdata_reg;
endmodule // two_level_interrupt_controller
`default_nettype wire

/* sim/irq_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_properties
    import irq_ctrl_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic rst_b, // reset, active low
    input wire logic [7:0] sfr_addr, // register address
    input wire logic [7:0] sfr_wdata, // byte write data
    input wire logic sfr_wr, // byte write strobe
    input wire logic [7:0] sfr_rdata, // read data
    input wire logic instr_boundary, // instruction ends
    input wire logic return_from_irq_instr, // return completes
    input wire logic call_ack, // long call starts
    input wire logic irq_req, // vector request
    input wire logic [3:0] irq_vector, // vector index
    input wire logic in_service_hi, // high routine active
    input wire logic in_service_lo // low routine active
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic mapped; // address names one of the three registers
    assign mapped = sfr_addr inside {MASK_ADDR, LEVEL_ADDR, EXT_LEVEL_ADDR};
    // a latched request may not move or vanish before the core takes it
    a_req_holds: assert property (irq_req && !call_ack |=> irq_req && $stable(irq_vector))
        else $error("request changed before acknowledge");
    a_ack_drops: assert property (irq_req && call_ack |=> !irq_req)
        else $error("request stood after acknowledge");
    a_ack_serves: assert property (irq_req && call_ack |=> in_service_hi || in_service_lo)
        else $error("no service level after acknowledge");
    a_preempt_low: assert property (in_service_lo && irq_req && call_ack |=> in_service_hi)
        else $error("low routine not preempted");
    a_high_alone: assert property (in_service_hi |-> !irq_req)
        else $error("request during high routine");
    a_ret_waits: assert property (return_from_irq_instr && !irq_req |=>
        !irq_req ##1 !irq_req) else $error("request before next instruction");
    a_vec_range: assert property (irq_req |-> irq_vector < 4'hE)
        else $error("vector out of range");
    a_unmapped_zero: assert property (!mapped |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_level_msb: assert property (sfr_addr == LEVEL_ADDR |=> sfr_rdata[7])
        else $error("level bit seven read zero");
    a_byte_write: assert property (sfr_wr && sfr_addr != LEVEL_ADDR && mapped
        |=> sfr_rdata == $past(sfr_wdata)) else $error("byte write not read back");
    c_ack: cover property (irq_req && call_ack);
    c_nested: cover property (in_service_hi && in_service_lo);
    c_return: cover property (return_from_irq_instr ##1 instr_boundary);
endmodule // irq_ctrl_properties
bind two_level_interrupt_controller irq_ctrl_properties chk (.*);
`default_nettype wire

/* sim/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic ref_clk, // system clock
    input wire logic rst_b, // reset, active low
    input wire logic irq_req, // vector request
    input wire logic [3:0] ack_delay, // how slow the core answers
    input wire logic ret_go, // routine ends now
    output logic instr_boundary, // instruction ends
    output logic return_from_irq_instr, // return completes
    output logic call_ack // long call starts
);
    logic [3:0] wait_cnt; // cycles the request has stood
    logic [1:0] phase; // four-cycle instructions, so boundaries are sparse
    // ack is one pulse per request, never before the request is seen
    always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b)
            {wait_cnt, phase, instr_boundary, return_from_irq_instr, call_ack} <= '0;
        else
        begin
            phase <= phase + 2'h1;
            instr_boundary <= phase == 2'h3;
            return_from_irq_instr <= ret_go;
            call_ack <= irq_req && !call_ack && wait_cnt >= ack_delay;
            wait_cnt <= (irq_req && !call_ack) ? wait_cnt + 4'h1 : 4'h0;
        end
endmodule // core_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import irq_ctrl_pkg::*;
    logic ref_clk = 0, rst_b = 0, sfr_wr = 0, sfr_bit_wr = 0, sfr_bit_val = 0, ret_go = 0;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, src = 0; // src: seven sources + t2 high
    logic [2:0] sfr_bit_sel = 0;
    logic [6:0] ext_pend = 0;
    logic [3:0] ack_delay = 0, irq_vector;
    logic instr_boundary, return_from_irq_instr, call_ack, irq_req, in_service_hi, in_service_lo;
    logic [15:0] lfsr = 16'h73D1; // fixed seed
    logic [7:0] mask_v = 0; // mask written this round, for the expectation
    int errors = 0, tests_run = 0;
    two_level_interrupt_controller dut (.*, .ext_irq_line0(src[0]), .timer0_overflow_flag(src[1]),
        .ext_irq_line1(src[2]), .timer1_overflow_flag(src[3]), .serial_port_pend(src[4]),
        .timer2_low_overflow_flag(src[5]), .timer2_high_overflow_flag(src[7]),
        .serial_iface_pend(src[6]));
    core_model core (.*);
    initial forever #20 ref_clk = ~ref_clk;
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // winner index, or 5'h10 when nothing may be taken; all levels low here
    function automatic logic [4:0] pick(input logic [7:0] m, input logic [7:0] p, input logic [6:0] e);
        logic [13:0] v;
        v = {e, m[6:0] & {p[6], p[5] | p[7], p[4:0]}};
        if (!m[7])
            return 5'h10;
        for (int i = 0; i < 14; i++)
            if (v[i])
                return 5'(i);
        return 5'h10;
    endfunction
    task automatic wrap_up();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // bus tasks start and end on a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, d};
        @(posedge ref_clk) sfr_wr <= 0;
        @(posedge ref_clk);
    endtask
    task automatic bw(input logic [7:0] a, input logic [2:0] b, input logic v);
        {sfr_bit_wr, sfr_addr, sfr_bit_sel, sfr_bit_val} <= {1'b1, a, b, v};
        @(posedge ref_clk) sfr_bit_wr <= 0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr_addr <= a;
        @(posedge ref_clk);
        #1 chk("sfr_rdata", e, sfr_rdata);
        @(posedge ref_clk);
    endtask
    task automatic look(input logic [4:0] e);
        #1 chk("irq_req", {7'h0, e != 5'h10}, {7'h0, irq_req});
        if (e != 5'h10)
            chk("irq_vector", {4'h0, e[3:0]}, {4'h0, irq_vector});
        @(posedge ref_clk);
    endtask
    // samples between edges, so the acknowledge cycle is never raced
    task automatic wait_ack();
        int n;
        n = 0;
        #1;
        while (n < 30 && !(irq_req === 1'b1 && call_ack === 1'b1))
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("call_taken", 8'h1, {7'h0, irq_req && call_ack});
        if (n >= 30)
            wrap_up();
        @(posedge ref_clk);
    endtask
    task automatic leave();
        ret_go <= 1;
        @(posedge ref_clk) ret_go <= 0;
        repeat (6) @(posedge ref_clk);
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1;
        @(posedge ref_clk);
        rd(MASK_ADDR, MASK_RESET);
        rd(LEVEL_ADDR, 8'h80);
        rd(EXT_LEVEL_ADDR, 8'h00);
        rd(8'hAA, 8'h00);
        // random masks and pending sets with a slow or prompt core
        repeat (60)
        begin
            lfsr = step(lfsr);
            mask_v = lfsr[7:0];
            wr(MASK_ADDR, mask_v);
            lfsr = step(step(lfsr));
            {src, ext_pend, ack_delay} <= {lfsr[7:0], lfsr[14:8] & lfsr[6:0], 2'h0, lfsr[9:8]};
            @(posedge ref_clk);
            look(pick(mask_v, lfsr[7:0], lfsr[14:8] & lfsr[6:0]));
            {src, ext_pend} <= '0;
            if (irq_req === 1'b1)
            begin
                wait_ack();
                leave();
            end
        end
        ack_delay <= 4'h0;
        wr(LEVEL_ADDR, 8'h7F);
        bw(LEVEL_ADDR, 3'h7, 1'b0);
        rd(LEVEL_ADDR, 8'hFF);
        wr(EXT_LEVEL_ADDR, 8'hBF);
        rd(EXT_LEVEL_ADDR, 8'hBF);
        wr(EXT_LEVEL_ADDR, 8'h00);
        wr(LEVEL_ADDR, 8'h02);
        wr(MASK_ADDR, 8'h00);
        bw(MASK_ADDR, 3'h7, 1'b1);
        bw(MASK_ADDR, 3'h0, 1'b1);
        bw(MASK_ADDR, 3'h1, 1'b1);
        rd(MASK_ADDR, 8'h83);
        src <= 8'h03;
        @(posedge ref_clk);
        look(5'h01);
        wait_ack();
        src <= 8'h01;
        repeat (8) @(posedge ref_clk);
        look(5'h10);
        ret_go <= 1;
        @(posedge ref_clk) ret_go <= 0;
        wait_ack();
        #1 chk("irq_vector", 8'h00, {4'h0, irq_vector});
        repeat (6) @(posedge ref_clk);
        look(5'h10);
        src <= 8'h03;
        @(posedge ref_clk);
        look(5'h01);
        wait_ack();
        #1 chk("in_service", 8'h3, {6'h0, in_service_hi, in_service_lo});
        wrap_up();
    end
endmodule // tb
`default_nettype wire
